/* design/acdiv_pkg.sv */
// Purpose: Constants and types of the sample clock divider and delay block
// Assumes: Serial port of 3 wires, 16-bit instruction then one data byte
// Notes: Behaviour
// Behaviour
// - Divide sample clock by one, two or four
// - SYSREF forces divider to programmed start state
// - Half-period divider phase delay, register enabled
// - Half-period change keeps serial link stable
// - Mode field picks fine or fine plus superfine
// - Fine delay has 16-step and 192-step options
// - Superfine is unsigned, quarter picosecond steps
// - Fine delay byte spans 192 steps
// - Superfine delay byte spans 128 steps
// - Superfine only with mode code two or six
// - Delay changes apply as the write completes
// - Enabling fine delay resets the datapath
// - Fine or superfine rewrites keep link stable
// - Two-stage duty stabilizer on after reset
// - Divider output has a 50% duty cycle
package acdiv_pkg;
   localparam int ADDR_W = 15;
   localparam int INSTR_BITS = 16;
   localparam int DATA_BITS = 8;
   localparam logic [ADDR_W-1:0] OFS_DIV_RATIO = 15'h0108;
   localparam logic [ADDR_W-1:0] OFS_HALF_DELAY = 15'h0109;
   localparam logic [ADDR_W-1:0] OFS_DELAY_MODE = 15'h0110;
   localparam logic [ADDR_W-1:0] OFS_SUPERFINE = 15'h0111;
   localparam logic [ADDR_W-1:0] OFS_FINE = 15'h0112;
   localparam logic [ADDR_W-1:0] OFS_DUTY_A = 15'h011c;
   localparam logic [ADDR_W-1:0] OFS_DUTY_B = 15'h011e;
   // Divide ratio field [1:0], start state [6:4], realign enable [7]
   localparam int RATIO_LSB = 0;
   localparam int START_LSB = 4;
   localparam int REALIGN_BIT = 7;
   localparam logic [1:0] RATIO_DIV1 = 2'h0;
   localparam logic [1:0] RATIO_DIV2 = 2'h1;
   localparam logic [1:0] RATIO_DIV4 = 2'h3;
   // Half-period field: enable [0], steps [3:1]
   localparam int HALF_EN_BIT = 0;
   localparam int HALF_STEPS_LSB = 1;
   // Mode field [2:0]; bit 2 picks the 192-step fine option
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SF_A = 3'h2;
   localparam logic [2:0] MODE_SF_B = 3'h6;
   localparam int MODE_WIDE_BIT = 2;
   localparam logic [7:0] FINE_MAX_16 = 8'h0f;
   localparam logic [7:0] FINE_MAX_192 = 8'hbf;
   localparam logic [7:0] SUPERFINE_MAX = 8'h7f;
   localparam int DUTY_EN_BIT = 0;
   localparam logic [7:0] RST_DIV_RATIO = 8'h00;
   localparam logic [7:0] RST_HALF_DELAY = 8'h00;
   localparam logic [7:0] RST_DELAY_MODE = 8'h00;
   localparam logic [7:0] RST_SUPERFINE = 8'h00;
   localparam logic [7:0] RST_FINE = 8'h00;
   localparam logic [7:0] RST_DUTY = 8'h01;

   typedef enum logic [2:0] {
      ACDIV_IDLE = 3'b001,
      ACDIV_INSTR = 3'b010,
      ACDIV_DATA = 3'b100
   } acdiv_spi_state_t;

   typedef struct packed {
      logic [2:0] mode;
      logic fine_wide;
      logic [7:0] fine;
      logic [7:0] superfine;
   } acdiv_delay_t;
endpackage

/* design/acdiv_top.sv */
// Purpose: Sample clock divider with SYSREF realign and edge delay controls
// Assumes: Sample clock, SYSREF and serial pins are slow next to i_mclk
// Notes: Phase moves only by stretching the divided clock
`timescale 1ns/10ps
`default_nettype none
module acdiv_top
   import acdiv_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_sample_clk,
   input wire logic i_sysref,
   input wire logic i_spi_csb,
   input wire logic i_spi_sclk,
   input wire logic i_spi_sdio,
   output logic o_spi_sdio,
   output logic o_spi_sdio_oe,
   output logic o_div_clk,
   output logic o_datapath_rst,
   output acdiv_delay_t o_delay,
   output logic o_duty_stabilizer_stage_one,
   output logic o_duty_stabilizer_stage_two
);
   // Synchronisers; third stage only for edge detection
   logic [2:0] clk_sync;
   logic [2:0] ref_sync;
   logic [2:0] sclk_sync;
   logic [1:0] csb_sync;
   logic [1:0] sdio_sync;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clk_sync <= 3'h0;
         ref_sync <= 3'h0;
         sclk_sync <= 3'h0;
         csb_sync <= 2'h3;
         sdio_sync <= 2'h0;
      end else begin
         clk_sync <= {clk_sync[1:0], i_sample_clk};
         ref_sync <= {ref_sync[1:0], i_sysref};
         sclk_sync <= {sclk_sync[1:0], i_spi_sclk};
         csb_sync <= {csb_sync[0], i_spi_csb};
         sdio_sync <= {sdio_sync[0], i_spi_sdio};
      end
   end
   logic clk_edge;
   logic ref_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic csb;
   assign clk_edge = clk_sync[2] ^ clk_sync[1];
   assign ref_rise = ref_sync[1] & ~ref_sync[2];
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   assign csb = csb_sync[1];

   // Serial port: R/W bit, 15-bit address, one data byte, MSB first
   acdiv_spi_state_t state;
   logic [4:0] bit_cnt;
   logic [INSTR_BITS-1:0] instr;
   logic [DATA_BITS-1:0] wdata;
   logic [DATA_BITS-1:0] rshift;
   logic rd_op;
   logic [ADDR_W-1:0] addr;
   logic wr_fire;
   logic rd_load;
   logic [DATA_BITS-1:0] rdata;
   logic [INSTR_BITS-1:0] next_instr;
   logic [DATA_BITS-1:0] next_wdata;
   assign next_instr = {instr[INSTR_BITS-2:0], sdio_sync[1]};
   assign next_wdata = {wdata[DATA_BITS-2:0], sdio_sync[1]};

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= ACDIV_IDLE;
         bit_cnt <= 5'h00;
         instr <= '0;
         wdata <= '0;
         rd_op <= 1'b0;
         addr <= '0;
         wr_fire <= 1'b0;
         rd_load <= 1'b0;
      end else begin
         wr_fire <= 1'b0;
         rd_load <= 1'b0;
         if (csb) begin
            state <= ACDIV_IDLE;
         end else begin
            case (state)
               ACDIV_IDLE: begin
                  state <= ACDIV_INSTR;
                  bit_cnt <= 5'h00;
               end
               ACDIV_INSTR: begin
                  if (sclk_rise) begin
                     instr <= next_instr;
                     bit_cnt <= bit_cnt + 5'h01;
                     if (bit_cnt == 5'(INSTR_BITS - 1)) begin
                        rd_op <= next_instr[INSTR_BITS-1];
                        addr <= next_instr[ADDR_W-1:0];
                        rd_load <= 1'b1;
                        bit_cnt <= 5'h00;
                        state <= ACDIV_DATA;
                     end
                  end
               end
               ACDIV_DATA: begin
                  if (sclk_rise && bit_cnt != 5'(DATA_BITS)) begin
                     wdata <= next_wdata;
                     bit_cnt <= bit_cnt + 5'h01;
                     // Byte lands on the last rising edge
                     if (bit_cnt == 5'(DATA_BITS - 1) && !rd_op) begin
                        wr_fire <= 1'b1;
                     end
                  end
               end
               default: state <= ACDIV_IDLE;
            endcase
         end
      end
   end

   // Register file
   logic [7:0] div_ratio_reg;
   logic [7:0] half_delay_reg;
   logic [7:0] duty_a_reg;
   logic [7:0] duty_b_reg;
   logic [7:0] mode_reg;
   logic [7:0] superfine_reg;
   logic [7:0] fine_reg;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_ratio_reg <= RST_DIV_RATIO;
         half_delay_reg <= RST_HALF_DELAY;
         mode_reg <= RST_DELAY_MODE;
         superfine_reg <= RST_SUPERFINE;
         fine_reg <= RST_FINE;
         duty_a_reg <= RST_DUTY;
         duty_b_reg <= RST_DUTY;
      end else if (wr_fire) begin
         if (addr == OFS_DIV_RATIO) begin
            div_ratio_reg <= wdata;
         end else if (addr == OFS_HALF_DELAY) begin
            half_delay_reg <= wdata;
         end else if (addr == OFS_DELAY_MODE) begin
            mode_reg <= wdata;
         end else if (addr == OFS_SUPERFINE) begin
            superfine_reg <= wdata;
         end else if (addr == OFS_FINE) begin
            fine_reg <= wdata;
         end else if (addr == OFS_DUTY_A) begin
            duty_a_reg <= wdata;
         end else if (addr == OFS_DUTY_B) begin
            duty_b_reg <= wdata;
         end
      end
   end

   always_comb begin
      if (addr == OFS_DIV_RATIO) begin
         rdata = div_ratio_reg;
      end else if (addr == OFS_HALF_DELAY) begin
         rdata = half_delay_reg;
      end else if (addr == OFS_DELAY_MODE) begin
         rdata = mode_reg;
      end else if (addr == OFS_SUPERFINE) begin
         rdata = superfine_reg;
      end else if (addr == OFS_FINE) begin
         rdata = fine_reg;
      end else if (addr == OFS_DUTY_A) begin
         rdata = duty_a_reg;
      end else if (addr == OFS_DUTY_B) begin
         rdata = duty_b_reg;
      end else begin
         rdata = 8'h00;
      end
   end

   // Read data leaves on falling edges so the host samples on rising ones
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rshift <= 8'h00;
         o_spi_sdio <= 1'b0;
         o_spi_sdio_oe <= 1'b0;
      end else begin
         o_spi_sdio_oe <= !csb && state == ACDIV_DATA && rd_op;
         // Load once addr has settled, else the old register goes out
         if (rd_load) begin
            rshift <= rdata;
         end else if (sclk_fall && rd_op) begin
            o_spi_sdio <= rshift[DATA_BITS-1];
            rshift <= {rshift[DATA_BITS-2:0], 1'b0};
         end
      end
   end

   // Divider: count input half periods, period is twice the ratio
   logic [2:0] ratio;
   logic [2:0] mask;
   logic [2:0] cnt;
   logic [3:0] hold;
   logic [2:0] applied_delay;
   logic [2:0] want_delay;
   logic [2:0] next_cnt;
   logic realign;
   always_comb begin
      case (div_ratio_reg[RATIO_LSB +: 2])
         RATIO_DIV2: ratio = 3'h2;
         RATIO_DIV4: ratio = 3'h4;
         default: ratio = 3'h1;
      endcase
   end
   assign mask = 3'((ratio << 1) - 3'h1);
   assign want_delay = half_delay_reg[HALF_EN_BIT] ?
      half_delay_reg[HALF_STEPS_LSB +: 3] : 3'h0;
   assign realign = ref_rise && div_ratio_reg[REALIGN_BIT];
   assign next_cnt = (clk_edge && hold == 4'h0) ? ((cnt + 3'h1) & mask) : (cnt & mask);

   // Phase moves by holding the count, so no pulse is ever cut short
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt <= 3'h0;
         hold <= 4'h0;
         applied_delay <= 3'h0;
         o_div_clk <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_div_clk <= next_cnt < ratio;
         if (realign) begin
            // Lag the count back to the programmed start state
            hold <= {1'b0, (cnt - div_ratio_reg[START_LSB +: 3]) & mask};
         end else if (want_delay != applied_delay) begin
            applied_delay <= want_delay;
            hold <= hold + {1'b0, (want_delay - applied_delay) & mask};
         end else if (clk_edge && hold != 4'h0) begin
            hold <= hold - 4'h1;
         end
      end
   end

   // Delay outputs follow the registers one cycle after the write
   logic [7:0] fine_cap;
   logic sf_mode;
   assign sf_mode = mode_reg[2:0] == MODE_SF_A || mode_reg[2:0] == MODE_SF_B;
   assign fine_cap = mode_reg[MODE_WIDE_BIT] ? FINE_MAX_192 : FINE_MAX_16;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_delay <= '0;
      end else begin
         o_delay.mode <= mode_reg[2:0];
         o_delay.fine_wide <= mode_reg[MODE_WIDE_BIT];
         o_delay.fine <= (mode_reg[2:0] == MODE_OFF) ? 8'h00 :
            (fine_reg > fine_cap ? fine_cap : fine_reg);
         o_delay.superfine <= !sf_mode ? 8'h00 :
            (superfine_reg > SUPERFINE_MAX ? SUPERFINE_MAX : superfine_reg);
      end
   end

   // Only a mode write from off to on resets the datapath
   logic mode_enable;
   assign mode_enable = wr_fire && addr == OFS_DELAY_MODE && mode_reg[2:0] == MODE_OFF &&
      wdata[2:0] != MODE_OFF;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_datapath_rst <= 1'b0;
      end else begin
         o_datapath_rst <= mode_enable;
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_duty_stabilizer_stage_one <= 1'b1;
         o_duty_stabilizer_stage_two <= 1'b1;
      end else begin
         o_duty_stabilizer_stage_one <= duty_a_reg[DUTY_EN_BIT];
         o_duty_stabilizer_stage_two <= duty_b_reg[DUTY_EN_BIT];
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   sequence s_fine_write;
      wr_fire && addr == OFS_FINE && mode_reg[2:0] != MODE_OFF;
   endsequence
   sequence s_mode_on;
      mode_enable;
   endsequence

   a_ratio_count: assert property (clk_edge && hold == 4'h0 && !realign
      |=> cnt == (($past(cnt) + 3'h1) & $past(mask)))
      else $error("divider count did not advance");
   a_sysref_start: assert property (realign
      |=> hold == {1'b0, ($past(cnt) - $past(div_ratio_reg[START_LSB +: 3])) & $past(mask)})
      else $error("realign lag wrong");
   a_hold_stretch: assert property (hold != 4'h0 && $stable(ratio)
      |=> cnt == $past(cnt) && $stable(o_div_clk))
      else $error("divided clock moved while held");
   a_duty_half: assert property (!$past(i_sys_rst) |-> o_div_clk == (cnt < $past(ratio)))
      else $error("divided clock duty wrong");
   a_superfine_gate: assert property (o_delay.superfine != 8'h00
      |-> o_delay.mode == MODE_SF_A || o_delay.mode == MODE_SF_B)
      else $error("superfine active in wrong mode");
   a_fine_limit: assert property (o_delay.fine <= FINE_MAX_192)
      else $error("fine delay over range");
   a_fine_apply: assert property (s_fine_write ##1 1'b1
      |=> o_delay.fine == (fine_reg > fine_cap ? fine_cap : fine_reg))
      else $error("fine delay not applied at once");
   a_dp_rst_pulse: assert property (s_mode_on |=> o_datapath_rst ##1 !o_datapath_rst)
      else $error("datapath reset not one pulse");
   a_half_delay: assert property ($changed(want_delay) && !realign
      |=> hold != 4'h0 || $past(((want_delay - applied_delay) & mask) == 3'h0))
      else $error("half-period delay ignored");
endmodule
`default_nettype wire

/* testbench/acdiv_host_model.sv */
// Purpose: Sample clock source and serial host
// Assumes: Sample clock in step with i_mclk, started after ratio write
// Notes: Released data line shows inverse of last level
`timescale 1ns/10ps
`default_nettype none
module acdiv_host_model #(
   parameter int SC_HALF = 8,
   parameter int SPI_HALF = 6
) (
   input wire logic i_mclk,
   input wire logic i_sdio_dev,
   input wire logic i_sdio_dev_oe,
   output logic o_sample_clk,
   output logic o_csb,
   output logic o_sclk,
   output logic o_sdio
);
   int sc_cnt = 0;
   logic sc_run = 1'b0;
   logic drv = 1'b0;
   logic drv_oe = 1'b0;
   logic last = 1'b0;
   initial begin
      o_sample_clk = 1'b0;
      o_csb = 1'b1;
      o_sclk = 1'b0;
   end
   always @(posedge i_mclk) begin
      if (sc_run) begin
         sc_cnt <= (sc_cnt == SC_HALF - 1) ? 0 : sc_cnt + 1;
         if (sc_cnt == SC_HALF - 1) begin
            o_sample_clk <= ~o_sample_clk;
         end
      end
      last <= o_sdio;
   end
   // Clock stays still until the host has set the ratio
   task automatic start_clock();
      sc_run <= 1'b1;
   endtask
   // Nobody driving: toggle so a stale bit never passes
   assign o_sdio = i_sdio_dev_oe ? i_sdio_dev : (drv_oe ? drv : ~last);
   // Whole frame MSB first; sclk idles low between frames
   task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [23:0] sh;
      sh = {r, a, d};
      q = 8'h00;
      @(posedge i_mclk);
      o_csb <= 1'b0;
      drv_oe <= 1'b1;
      for (int i = 23; i >= 0; i--) begin
         drv <= sh[i];
         if (r && i == 7) begin
            drv_oe <= 1'b0;
         end
         repeat (SPI_HALF) @(posedge i_mclk);
         q = {q[6:0], o_sdio};
         o_sclk <= 1'b1;
         repeat (SPI_HALF) @(posedge i_mclk);
         o_sclk <= 1'b0;
      end
      drv_oe <= 1'b0;
      repeat (SPI_HALF) @(posedge i_mclk);
      o_csb <= 1'b1;
      repeat (8) @(posedge i_mclk);
   endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench of divider and delay block
// Assumes: Sample clock period 16 cycles of i_mclk
// Notes: Phase is rise time modulo divided period
`timescale 1ns/10ps
`default_nettype none
module tb;
   import acdiv_pkg::*;
   localparam int H = 8;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_sysref = 1'b0;
   wire logic sc, csb, sclk, sdio, d_sdio, d_oe, div_clk, dp_rst, st1, st2;
   wire acdiv_delay_t dly;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int n_dp = 0;
   int run_len = 0;
   int last_hi = 0;
   int last_lo = 0;
   int rise_ph = 0;
   int min_len = 0;
   logic div_q = 1'b0;
   logic [7:0] rd;
   always #2 i_mclk = ~i_mclk;
   acdiv_host_model acdiv_host_model_inst (.i_mclk(i_mclk), .i_sdio_dev(d_sdio),
      .i_sdio_dev_oe(d_oe), .o_sample_clk(sc), .o_csb(csb), .o_sclk(sclk), .o_sdio(sdio));
   acdiv_top acdiv_top_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sample_clk(sc),
      .i_sysref(i_sysref), .i_spi_csb(csb), .i_spi_sclk(sclk), .i_spi_sdio(sdio),
      .o_spi_sdio(d_sdio), .o_spi_sdio_oe(d_oe), .o_div_clk(div_clk),
      .o_datapath_rst(dp_rst), .o_delay(dly), .o_duty_stabilizer_stage_one(st1),
      .o_duty_stabilizer_stage_two(st2));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      acdiv_host_model_inst.xfer(1'b0, a, d, rd);
   endtask
   task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
      acdiv_host_model_inst.xfer(1'b1, a, 8'h00, rd);
      chk({16'h0000, rd}, {16'h0000, e});
   endtask
   // Pulse widths and phase of the divided clock
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      div_q <= div_clk;
      run_len <= (div_clk !== div_q) ? 1 : run_len + 1;
      if (dp_rst === 1'b1) begin
         n_dp <= n_dp + 1;
      end
      if (div_clk !== div_q) begin
         if (div_q === 1'b1) begin
            last_hi <= run_len;
         end else begin
            last_lo <= run_len;
            rise_ph <= cyc % 64;
         end
         if (min_len > 0) begin
            chk(24'((run_len < min_len) ? run_len : min_len), 24'(min_len));
         end
      end
   end
   task automatic t_reset();
      logic [14:0] ofs [7];
      ofs = '{OFS_DIV_RATIO, OFS_HALF_DELAY, OFS_DELAY_MODE, OFS_SUPERFINE, OFS_FINE,
              OFS_DUTY_A, OFS_DUTY_B};
      chk({1'b0, dly, st1, st2, dp_rst}, 24'h000006);
      for (int i = 0; i < 7; i++) begin
         rdchk(ofs[i], (i >= 5) ? 8'h01 : 8'h00);
      end
      wr(15'h010a, 8'h55);
      rdchk(15'h010a, 8'h00);
      wr(OFS_DUTY_A, 8'h00);
      chk({22'h0, st1, st2}, 24'h1);
      wr(OFS_DUTY_B, 8'h00);
      wr(OFS_DUTY_A, 8'h01);
      chk({22'h0, st1, st2}, 24'h2);
      rdchk(OFS_DUTY_B, 8'h00);
   endtask
   task automatic t_ratio();
      logic [1:0] code [3];
      int rat [3];
      code = '{RATIO_DIV1, RATIO_DIV2, RATIO_DIV4};
      rat = '{1, 2, 4};
      wr(OFS_DIV_RATIO, {6'h00, RATIO_DIV1});
      acdiv_host_model_inst.start_clock();
      for (int i = 0; i < 3; i++) begin
         wr(OFS_DIV_RATIO, {6'h00, code[i]});
         repeat (200) @(posedge i_mclk);
         chk(24'(last_hi), 24'(rat[i] * H));
         chk(24'(last_lo), 24'(rat[i] * H));
      end
   endtask
   task automatic t_delay();
      int base;
      logic [2:0] m;
      logic [7:0] ef;
      logic [7:0] es;
      base = n_dp;
      wr(OFS_FINE, 8'hff);
      wr(OFS_SUPERFINE, 8'hff);
      chk(24'(n_dp - base), 24'h0);
      for (int i = 1; i < 8; i++) begin
         m = 3'(i);
         wr(OFS_DELAY_MODE, {5'h00, m});
         ef = m[2] ? 8'd191 : 8'd15;
         es = (m == 3'h2 || m == 3'h6) ? 8'd127 : 8'd0;
         chk({4'h0, dly}, {4'h0, m, m[2], ef, es});
      end
      chk(24'(n_dp - base), 24'h1);
      wr(OFS_DELAY_MODE, 8'h00);
      chk({4'h0, dly}, 24'h0);
      wr(OFS_DELAY_MODE, 8'h02);
      chk(24'(n_dp - base), 24'h2);
      // Mode two is the 16-step option, so stay under its clamp
      wr(OFS_FINE, 8'h0a);
      chk({16'h0, dly.fine}, 24'h0a);
      chk(24'(n_dp - base), 24'h2);
   endtask
   task automatic t_half();
      int p0;
      int base;
      min_len = 4 * H;
      p0 = rise_ph;
      base = n_dp;
      wr(OFS_HALF_DELAY, 8'h07);
      repeat (300) @(posedge i_mclk);
      chk(24'((rise_ph - p0 + 64) % 64), 24'(3 * H));
      chk(24'(n_dp - base), 24'h0);
   endtask
   task automatic t_sysref();
      int p [2];
      int off [2];
      off = '{5, 29};
      wr(OFS_DIV_RATIO, {1'b1, 3'h2, 2'h0, RATIO_DIV4});
      for (int k = 0; k < 2; k++) begin
         while (cyc % 64 != off[k]) @(posedge i_mclk);
         i_sysref <= 1'b1;
         repeat (20) @(posedge i_mclk);
         i_sysref <= 1'b0;
         repeat (300) @(posedge i_mclk);
         p[k] = rise_ph;
      end
      chk(24'((p[1] - p[0] + 64) % 64), 24'd24);
      min_len = 0;
   endtask
   initial begin
      repeat (6) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_mclk);
      t_reset();
      t_ratio();
      t_delay();
      t_half();
      t_sysref();
      close_out();
   end
   // Whole run is about 11000 cycles
   initial begin
      repeat (40000) @(posedge i_mclk);
      n_fail++;
      close_out();
   end
endmodule
`default_nettype wire
